// *** fsr_pkg.sv ***
// Constants for the FIFO status and test-control register bank.
// Assumes byte-wide register access from the host port logic.
package fsr_pkg;
    localparam logic [7:0] ADDR_TEST_CTRL = 8'h1b;
    localparam logic [7:0] ADDR_FIFO_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_TX_LEN_HIGH = 8'h1d;
    localparam logic [7:0] TEST_CTRL_RESET = 8'h00;
    localparam logic [7:0] TX_LEN_HIGH_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int BIT_CODER_FAST = 0;
    localparam int BIT_DEC_TEST = 1;
    localparam int BIT_IO_LO = 2;
    localparam int BIT_IO_HI = 3;
    localparam int BIT_RF_LEVEL = 5;
    // Bits that a stop condition clears and that hold the chip in test mode
    localparam logic [7:0] TEST_STOP_MASK = 8'h0e;
    localparam int FIFO_COUNT_W = 7;
    localparam int FIFO_OVF_BIT = 7;
endpackage

// *** fsr_fifo_tracker.sv ***
// Byte count and overflow flag of the transceiver FIFO.
// Assumes push, pop and flush are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fsr_fifo_tracker #(
    parameter int COUNT_W = fsr_pkg::FIFO_COUNT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic flush_i,
    output logic [COUNT_W-1:0] count_o,
    output logic overflow_o
);
    localparam logic [COUNT_W-1:0] COUNT_MAX = {COUNT_W{1'b1}};
    localparam logic [COUNT_W-1:0] COUNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic overflow;
    } fsr_track_state_type;

    fsr_track_state_type state_q;
    fsr_track_state_type state_d;

    always_comb
    begin
        state_d = state_q;
        if (flush_i)
        begin
            state_d.count = '0;
            state_d.overflow = 1'b0;
        end
        // A push in the flush cycle lands after the flush, so it is kept
        if (push_i && !pop_i)
        begin
            if (state_d.count == COUNT_MAX)
            begin
                state_d.overflow = 1'b1;
            end
            else
            begin
                state_d.count = state_d.count + COUNT_ONE;
            end
        end
        else if (pop_i && !push_i && state_d.count != '0)
        begin
            state_d.count = state_d.count - COUNT_ONE;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign count_o = state_q.count;
    assign overflow_o = state_q.overflow;
endmodule
`default_nettype wire

// *** fsr_fifo_status_test_regs.sv ***
// Test-control, FIFO status and transmit-length-high registers.
// Assumes the host port logic delivers decoded byte accesses and a
// one-cycle stop pulse on clk_i; rst_i is power-on reset with enable low.
`timescale 1ns/1ps
`default_nettype none
module fsr_fifo_status_test_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic stop_cond_i,
    input wire logic fifo_push_i,
    input wire logic fifo_pop_i,
    input wire logic fifo_flush_i,
    output logic test_mode_o,
    output logic decoder_test_o,
    output logic io_test_select_hi_o,
    output logic io_test_select_lo_o,
    output logic coder_fast_clock_o,
    output logic rf_level_check_o,
    output logic [7:0] tx_length_high_o,
    output logic [fsr_pkg::FIFO_COUNT_W-1:0] fifo_count_o,
    output logic fifo_overflow_o
);
    typedef struct packed {
        logic [7:0] test_ctrl;
        logic [7:0] tx_len_high;
        logic [7:0] rdata;
    } fsr_reg_state_type;

    fsr_reg_state_type state_q;
    fsr_reg_state_type state_d;
    logic wr_test;
    logic [7:0] status_byte;

    fsr_fifo_tracker #(
        .COUNT_W(fsr_pkg::FIFO_COUNT_W)
    ) u_tracker (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(fifo_push_i),
        .pop_i(fifo_pop_i),
        .flush_i(fifo_flush_i),
        .count_o(fifo_count_o),
        .overflow_o(fifo_overflow_o)
    );

    assign wr_test = reg_wr_i && reg_addr_i == fsr_pkg::ADDR_TEST_CTRL;
    // Status is a pure view; reading it feeds nothing back to the tracker
    assign status_byte = {fifo_overflow_o, fifo_count_o};

    always_comb
    begin
        state_d = state_q;
        if (stop_cond_i)
        begin
            state_d.test_ctrl = state_q.test_ctrl & ~fsr_pkg::TEST_STOP_MASK;
        end
        // A host write in the stop cycle is the later intent, so it wins
        if (wr_test)
        begin
            state_d.test_ctrl = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == fsr_pkg::ADDR_TX_LEN_HIGH)
        begin
            state_d.tx_len_high = reg_wdata_i;
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                fsr_pkg::ADDR_TEST_CTRL: state_d.rdata = state_q.test_ctrl;
                fsr_pkg::ADDR_FIFO_STATUS: state_d.rdata = status_byte;
                fsr_pkg::ADDR_TX_LEN_HIGH: state_d.rdata = state_q.tx_len_high;
                default: state_d.rdata = fsr_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q.test_ctrl <= fsr_pkg::TEST_CTRL_RESET;
            state_q.tx_len_high <= fsr_pkg::TX_LEN_HIGH_RESET;
            state_q.rdata <= fsr_pkg::RDATA_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Test mode needs only the stored bits 1 to 3, so it persists with no extra state
    assign test_mode_o = |(state_q.test_ctrl & fsr_pkg::TEST_STOP_MASK);
    assign decoder_test_o = state_q.test_ctrl[fsr_pkg::BIT_DEC_TEST];
    assign io_test_select_hi_o = state_q.test_ctrl[fsr_pkg::BIT_IO_HI];
    assign io_test_select_lo_o = state_q.test_ctrl[fsr_pkg::BIT_IO_LO];
    assign coder_fast_clock_o = state_q.test_ctrl[fsr_pkg::BIT_CODER_FAST];
    assign rf_level_check_o = state_q.test_ctrl[fsr_pkg::BIT_RF_LEVEL];
    assign tx_length_high_o = state_q.tx_len_high;
    assign reg_rdata_o = state_q.rdata;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_reset_zero;
        @(posedge clk_i) disable iff (1'b0)
        rst_i |-> (state_q.test_ctrl == 8'h00 && !test_mode_o);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("test register not zero in reset");

    property p_enter_test;
        wr_test && (reg_wdata_i & 8'h0e) != 8'h00 |=> test_mode_o;
    endproperty
    a_enter_test: assert property (p_enter_test) else $error("test mode not entered");

    property p_test_persist;
        test_mode_o && !stop_cond_i && !wr_test |=> test_mode_o;
    endproperty
    a_test_persist: assert property (p_test_persist) else $error("test mode dropped early");

    property p_stop_clears;
        stop_cond_i && !wr_test |=> !test_mode_o && !decoder_test_o
            && !io_test_select_hi_o && !io_test_select_lo_o;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear test bits");

    property p_decoder_bit;
        wr_test && reg_wdata_i[1] ##1 !stop_cond_i && !wr_test [*2]
            |=> decoder_test_o && test_mode_o;
    endproperty
    a_decoder_bit: assert property (p_decoder_bit) else $error("decoder test bit lost");

    property p_coder_clock;
        wr_test |=> coder_fast_clock_o == $past(reg_wdata_i[0])
            ##1 ($past(wr_test) || $stable(coder_fast_clock_o));
    endproperty
    a_coder_clock: assert property (p_coder_clock) else $error("coder clock bit wrong");

    property p_stop_keeps_coder;
        stop_cond_i && !wr_test |=> $stable(coder_fast_clock_o);
    endproperty
    a_stop_keeps_coder: assert property (p_stop_keeps_coder) else $error("stop hit coder bit");

    property p_overflow_set;
        fifo_push_i && !fifo_pop_i && !fifo_flush_i && fifo_count_o == 7'h7f
            |=> fifo_overflow_o && fifo_count_o == 7'h7f;
    endproperty
    a_overflow_set: assert property (p_overflow_set) else $error("overflow not flagged");

    property p_count_up;
        fifo_push_i && !fifo_pop_i && !fifo_flush_i && fifo_count_o != 7'h7f
            |=> fifo_count_o == $past(fifo_count_o) + 7'h01;
    endproperty
    a_count_up: assert property (p_count_up) else $error("count did not advance");

    property p_status_read;
        reg_rd_i && reg_addr_i == 8'h1c
            |=> reg_rdata_o == {$past(fifo_overflow_o), $past(fifo_count_o)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read data wrong");

    property p_read_no_effect;
        reg_rd_i && !fifo_push_i && !fifo_pop_i && !fifo_flush_i
            |=> $stable(fifo_count_o) && $stable(fifo_overflow_o);
    endproperty
    a_read_no_effect: assert property (p_read_no_effect) else $error("read changed FIFO state");

    property p_tx_len_write;
        reg_wr_i && reg_addr_i == 8'h1d |=> tx_length_high_o == $past(reg_wdata_i);
    endproperty
    a_tx_len_write: assert property (p_tx_len_write) else $error("length byte not stored");

    property p_pop_down;
        fifo_pop_i && !fifo_push_i && !fifo_flush_i && fifo_count_o != 7'h00
            |=> fifo_count_o == $past(fifo_count_o) - 7'h01;
    endproperty
    a_pop_down: assert property (p_pop_down) else $error("count did not drop");

    property p_pop_empty;
        fifo_pop_i && !fifo_push_i && !fifo_flush_i && fifo_count_o == 7'h00
            |=> fifo_count_o == 7'h00;
    endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("empty pop moved count");

    property p_flush_clears;
        fifo_flush_i && !fifo_push_i |=> fifo_count_o == 7'h00 && !fifo_overflow_o;
    endproperty
    a_flush_clears: assert property (p_flush_clears) else $error("flush failed");

    // Overflow stays up until a flush, so a late status read still sees it
    property p_overflow_sticky;
        fifo_overflow_o && !fifo_flush_i |=> fifo_overflow_o;
    endproperty
    a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow lost");

    property p_stop_idle;
        !test_mode_o && !wr_test |=> !test_mode_o;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("test mode entered");

    property p_rf_level_keep;
        stop_cond_i && !wr_test |=> $stable(rf_level_check_o);
    endproperty
    a_rf_level_keep: assert property (p_rf_level_keep) else $error("stop hit rf bit");

    property p_test_ctrl_read;
        reg_rd_i && reg_addr_i == fsr_pkg::ADDR_TEST_CTRL
            |=> reg_rdata_o == $past(state_q.test_ctrl);
    endproperty
    a_test_ctrl_read: assert property (p_test_ctrl_read) else $error("test read wrong");
endmodule
`default_nettype wire

// *** fsr_host.sv ***
// Host model: byte register writes and reads on the strobes.
// Assumes the bench calls its tasks; pins move at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        // Released data flips so a stale byte cannot pass for a hold
        wdata_o = ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench for the FIFO status and test-control register bank.
// Assumes the host model owns the register bus; FIFO events come from here.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b0;
    logic stop_i = 1'b0;
    logic push_i = 1'b0;
    logic pop_i = 1'b0;
    logic flush_i = 1'b0;
    logic [7:0] addr, wdata, rdata, txl, v;
    logic wr, rd, tm, dt, ioh, iol, cf, rfl, ovf;
    logic [6:0] cnt;
    int fail_count = 0;
    int check_count = 0;
    always #20 clk_i = ~clk_i;
    fsr_host host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    fsr_fifo_status_test_regs dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .stop_cond_i(stop_i), .fifo_push_i(push_i), .fifo_pop_i(pop_i),
        .fifo_flush_i(flush_i), .test_mode_o(tm), .decoder_test_o(dt),
        .io_test_select_hi_o(ioh), .io_test_select_lo_o(iol), .coder_fast_clock_o(cf),
        .rf_level_check_o(rfl), .tx_length_high_o(txl), .fifo_count_o(cnt),
        .fifo_overflow_o(ovf));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask
    task automatic t_reset;
        check({2'b00, rfl, tm, ioh, iol, dt, cf}, 8'h00);
        host.rd_reg(fsr_pkg::ADDR_TEST_CTRL, v);
        check(v, fsr_pkg::TEST_CTRL_RESET);
    endtask
    task automatic t_test;
        host.wr_reg(fsr_pkg::ADDR_TEST_CTRL, 8'h2f);
        check({2'b00, rfl, tm, ioh, iol, dt, cf}, 8'h3f);
        repeat (5) @(negedge clk_i);
        check({7'h00, tm}, 8'h01);
        pulse(stop_i);
        host.rd_reg(fsr_pkg::ADDR_TEST_CTRL, v);
        check(v, 8'h21);
        check({4'h0, tm, ioh, iol, dt}, 8'h00);
        host.wr_reg(fsr_pkg::ADDR_TEST_CTRL, 8'h04);
        check({6'h00, tm, iol}, 8'h03);
        pulse(stop_i);
        check({7'h00, tm}, 8'h00);
        // A write in the stop cycle is the later intent and wins
        fork
            host.wr_reg(fsr_pkg::ADDR_TEST_CTRL, 8'h02);
            pulse(stop_i);
        join
        check({6'h00, tm, dt}, 8'h03);
        pulse(stop_i);
        check({6'h00, tm, dt}, 8'h00);
    endtask
    task automatic t_fifo;
        pulse(flush_i);
        pulse(pop_i);
        check({ovf, cnt}, 8'h00);
        repeat (127) pulse(push_i);
        check({ovf, cnt}, 8'h7f);
        host.rd_reg(fsr_pkg::ADDR_FIFO_STATUS, v);
        check(v, 8'h7f);
        host.rd_reg(fsr_pkg::ADDR_FIFO_STATUS, v);
        check(v, 8'h7f);
        check({ovf, cnt}, 8'h7f);
        pulse(push_i);
        host.rd_reg(fsr_pkg::ADDR_FIFO_STATUS, v);
        check(v, 8'hff);
        pulse(pop_i);
        check({ovf, cnt}, 8'hfe);
        fork
            pulse(push_i);
            pulse(pop_i);
        join
        check({ovf, cnt}, 8'hfe);
        pulse(flush_i);
        check({ovf, cnt}, 8'h00);
    endtask
    task automatic t_txlen;
        host.wr_reg(fsr_pkg::ADDR_TX_LEN_HIGH, 8'ha5);
        check(txl, 8'ha5);
        host.wr_reg(fsr_pkg::ADDR_FIFO_STATUS, 8'h55);
        host.rd_reg(fsr_pkg::ADDR_FIFO_STATUS, v);
        check(v, 8'h00);
        host.rd_reg(8'h33, v);
        check(v, fsr_pkg::UNMAPPED_READ);
        host.rd_reg(fsr_pkg::ADDR_TX_LEN_HIGH, v);
        check(v, 8'ha5);
        host.wr_reg(fsr_pkg::ADDR_TEST_CTRL, 8'h02);
        check({6'h00, tm, dt}, 8'h03);
        @(negedge clk_i);
        rst_i = 1'b1;
        @(negedge clk_i);
        rst_i = 1'b0;
        check(txl, fsr_pkg::TX_LEN_HIGH_RESET);
        check({6'h00, tm, dt}, 8'h00);
        check(rdata, fsr_pkg::RDATA_RESET);
        host.rd_reg(fsr_pkg::ADDR_TEST_CTRL, v);
        check(v, fsr_pkg::TEST_CTRL_RESET);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Whole sequence is under 1000 cycles, so this only trips on a hang
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        // Reset rises after time zero so the async branch sees a real edge
        #1;
        rst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_test();
        t_fifo();
        t_txlen();
        wrap_up();
    end
endmodule
`default_nettype wire
